/* File: pcisp_slave.sv */
// Serial slave engine of the power-controller port: framing, addressing, data, alert
`timescale 1ns/1ps
`default_nettype none
module pcisp_slave
	import pcisp_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Serial lines
	input wire logic scl, // Serial clock from master
	input wire logic serial_data_input, // Data input line
	output logic serial_data_output_open_drain, // Drive level, always low
	output logic serial_data_output_oe, // High while pulling low
	// Address select pins
	input wire logic address_select_bit3,
	input wire logic address_select_bit2,
	input wire logic address_select_bit1,
	input wire logic address_select_bit0,
	// Interrupt state from event logic
	input wire logic interrupt_active,
	// Register events
	output logic clear_interrupt_pushbutton,
	output logic [7:0] pointer
);
	// ----------------------------------------
	// Synchronisers
	// ----------------------------------------
	logic [1:0] scl_s; // scl_s[0] only feeds scl_s[1]
	logic [1:0] sda_s;
	logic [3:0] ap_s0, ap_s1; // Address pin synchroniser
	logic scl_q, sda_q; // Delayed synchronised levels for edges

	// Two flops on the serial and address pins before use; interrupt_active is used as it comes
	always_ff @(posedge clk) begin
		scl_s <= {scl_s[0], scl};
		sda_s <= {sda_s[0], serial_data_input};
		ap_s0 <= {address_select_bit3, address_select_bit2,
			address_select_bit1, address_select_bit0};
		ap_s1 <= ap_s0;
		scl_q <= scl_s[1];
		sda_q <= sda_s[1];
	end

	wire scl_now = scl_s[1];
	wire sda_now = sda_s[1];
	wire scl_rise = scl_now && !scl_q; // Sample point
	wire scl_fall = !scl_now && scl_q; // Change point for driven data
	wire start_det = scl_now && scl_q && sda_q && !sda_now;
	wire stop_det = scl_now && scl_q && !sda_q && sda_now;

	// ----------------------------------------
	// Register store
	// ----------------------------------------
	pcisp_reg_if rif();

	pcisp_regs u_regs (
		.clk(clk),
		.reset(reset),
		.addr_pins_sync(ap_s1),
		.bus(rif.store),
		.clear_interrupt_pushbutton(clear_interrupt_pushbutton)
	);

	// ----------------------------------------
	// Engine state
	// ----------------------------------------
	pcisp_state_t state_q; // Byte phase
	logic [3:0] bit_q; // Bit index 0..8 in the current byte
	logic [7:0] shift_q; // Receive shift register
	logic [7:0] tx_q; // Transmit byte
	logic [7:0] ptr_q; // Register pointer
	logic drive_q; // Pull data line low
	logic read_q; // Current byte is sent by device
	logic ack_q; // Acknowledge bit of the last byte was low, whoever drove it
	logic lost_q; // Arbitration lost
	logic wr_q, rd_q; // Register strobes
	logic dir_read_q, glob_q; // Address byte flags kept for the ack bit
	logic addr_own_q, glob_ok_q; // Whether this device may acknowledge the address

	wire [6:0] own_addr = {PCISP_ADDR_UPPER, rif.slave_low};
	wire [7:0] rx_byte = {shift_q[6:0], sda_now}; // Byte completed at bit 7 rise
	wire addr_own = (rx_byte[7:1] == own_addr);
	wire addr_glob = (rx_byte[7:1] == PCISP_GLOBAL_ADDR);
	wire dir_read = rx_byte[0]; // Eighth bit is direction
	wire data_bit = (bit_q <= PCISP_BIT_LAST);
	wire ack_bit = (bit_q == PCISP_BIT_ACK);
	// Refresh read data one cycle after the pointer moves, long before the next fall
	wire reload = (state_q == PCISP_RDATA) && bit_q == 4'h0 && rd_q;

	// Saturating pointer advance: holds at the top, never wraps
	function automatic logic [7:0] pcisp_next_ptr(input logic [7:0] p);
		pcisp_next_ptr = (p >= PCISP_PTR_TOP) ? p : 8'(p + 8'h01);
	endfunction : pcisp_next_ptr

	// Byte sequencing on clock edges; START and STOP override any phase
	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= PCISP_IDLE;
			bit_q <= 4'h0;
			shift_q <= 8'h00;
			tx_q <= 8'h00;
			ptr_q <= PCISP_PTR_RESET;
			read_q <= 1'b0;
			ack_q <= 1'b0;
			lost_q <= 1'b0;
			wr_q <= 1'b0;
			rd_q <= 1'b0;
		end else begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			// Next byte comes from the advanced pointer
			if (reload) begin
				tx_q <= rif.rdata;
			end
			if (start_det) begin
				// Repeated START keeps the pointer
				state_q <= PCISP_ADDR;
				bit_q <= 4'h0;
				read_q <= 1'b0;
				lost_q <= 1'b0;
			end else if (stop_det) begin
				// STOP frees the bus; pointer-only write leaves registers alone
				state_q <= PCISP_IDLE;
				read_q <= 1'b0;
			end else if (state_q != PCISP_IDLE && state_q != PCISP_IGNORE && scl_rise) begin
				if (data_bit) begin
					shift_q <= rx_byte;
					// Arbitration: bus low while we released means another won
					if (state_q == PCISP_ALERT && tx_q[7] && !sda_now) begin
						lost_q <= 1'b1;
					end
					if (read_q) begin
						tx_q <= {tx_q[6:0], 1'b0};
					end
					bit_q <= 4'(bit_q + 4'h1);
					if (bit_q == PCISP_BIT_LAST) begin
						unique case (state_q)
							PCISP_ADDR: begin
								if (!(addr_own || addr_glob)) begin
									state_q <= PCISP_IGNORE;
								end
							end
							PCISP_CMD: ptr_q <= rx_byte;
							PCISP_WDATA: wr_q <= 1'b1;
							default: ;
						endcase
					end
				end else begin
					// Acknowledge bit: choose next phase
					bit_q <= 4'h0;
					ack_q <= !sda_now;
					unique case (state_q)
						PCISP_ADDR: begin
							if (!dir_read_q) begin
								state_q <= PCISP_CMD;
								read_q <= 1'b0;
							end else if (glob_q) begin
								// Alert response only with pending interrupt
								state_q <= interrupt_active ? PCISP_ALERT : PCISP_IGNORE;
								tx_q <= {own_addr, 1'b1};
								read_q <= interrupt_active;
							end else begin
								state_q <= PCISP_RDATA;
								tx_q <= rif.rdata;
								read_q <= 1'b1;
							end
						end
						PCISP_CMD: state_q <= PCISP_WDATA;
						PCISP_WDATA: ptr_q <= pcisp_next_ptr(ptr_q);
						PCISP_RDATA: begin
							// Byte done: advance, load next, stop on master NACK
							rd_q <= 1'b1;
							ptr_q <= pcisp_next_ptr(ptr_q);
							tx_q <= rif.rdata;
							if (sda_now) begin
								state_q <= PCISP_IGNORE;
							end
						end
						PCISP_ALERT: state_q <= PCISP_IGNORE;
						default: ;
					endcase
				end
			end
		end
	end

	// Address byte flags kept past the byte so the ack bit can use them
	always_ff @(posedge clk) begin
		if (reset) begin
			dir_read_q <= 1'b0;
			glob_q <= 1'b0;
		end else if (state_q == PCISP_ADDR && scl_rise && bit_q == PCISP_BIT_LAST) begin
			dir_read_q <= dir_read;
			glob_q <= addr_glob && !addr_own;
		end
	end

	// ----------------------------------------
	// Data line drive, changed only while clock low
	// ----------------------------------------
	// Drive decisions are taken on the falling edge so the line is stable while high
	wire ack_slot = ack_bit && !read_q &&
		(state_q == PCISP_CMD || state_q == PCISP_WDATA ||
		(state_q == PCISP_ADDR && (addr_own_q || glob_ok_q)));
	wire tx_slot = data_bit && read_q && !lost_q &&
		(state_q == PCISP_RDATA || state_q == PCISP_ALERT) && !tx_q[7];

	// Whether this device may acknowledge the address byte
	always_ff @(posedge clk) begin
		if (reset) begin
			addr_own_q <= 1'b0;
			glob_ok_q <= 1'b0;
		end else if (state_q == PCISP_ADDR && scl_rise && bit_q == PCISP_BIT_LAST) begin
			addr_own_q <= addr_own;
			// Global write always; global read only with interrupt
			glob_ok_q <= addr_glob && (!dir_read || interrupt_active);
		end
	end

	// Open-drain pull-down only; released on START, STOP and arbitration loss
	always_ff @(posedge clk) begin
		if (reset || start_det || stop_det) begin
			drive_q <= 1'b0;
		end else if (state_q == PCISP_ALERT && lost_q) begin
			drive_q <= 1'b0;
		end else if (scl_fall) begin
			drive_q <= ack_slot || tx_slot;
		end
	end

	// ----------------------------------------
	// Register interface
	// ----------------------------------------
	assign rif.addr = ptr_q;
	assign rif.wdata = shift_q;
	assign rif.wr = wr_q;
	assign rif.rd = reload;
	assign serial_data_output_open_drain = 1'b0;
	assign serial_data_output_oe = drive_q;
	assign pointer = ptr_q;
endmodule : pcisp_slave
`default_nettype wire

/* File: pcisp_pkg.sv */
// Package of constants and types for the power-controller serial slave port
package pcisp_pkg;
	// ----------------------------------------
	// Addressing
	// ----------------------------------------
	localparam logic [2:0] PCISP_ADDR_UPPER = 3'h2; // Fixed upper address bits 010
	localparam logic [6:0] PCISP_GLOBAL_ADDR = 7'h30; // Global 0x60/0x61 as seven bits
	localparam logic [7:0] PCISP_PTR_TOP = 8'h26; // Pointer holds here
	localparam logic [7:0] PCISP_PUSHBUTTON_REG = 8'h1A; // Global pushbutton register
	localparam int PCISP_CLEAR_INTERRUPT_PUSHBUTTON_BIT = 7; // Clear-interrupt pushbutton bit
	localparam logic [3:0] PCISP_BIT_LAST = 4'h7; // Index of last data bit in a byte
	localparam logic [3:0] PCISP_BIT_ACK = 4'h8; // Index of acknowledge bit
	localparam logic [7:0] PCISP_PTR_RESET = 8'h00; // Pointer after reset

	// ----------------------------------------
	// Byte phase state, Gray along the write path IDLE, ADDR, CMD, WDATA
	// ----------------------------------------
	typedef enum logic [2:0] {
		PCISP_IDLE = 3'h0, // Waiting for START
		PCISP_ADDR = 3'h1, // Receiving address byte
		PCISP_CMD = 3'h3, // Receiving command byte
		PCISP_WDATA = 3'h2, // Receiving data bytes
		PCISP_RDATA = 3'h6, // Sending register data
		PCISP_ALERT = 3'h7, // Sending own address in arbitration
		PCISP_IGNORE = 3'h5 // Not addressed, wait for STOP
	} pcisp_state_t;
endpackage : pcisp_pkg

/* File: pcisp_reg_if.sv */
// Interface carrying register access between the serial engine and register store
`timescale 1ns/1ps
`default_nettype none
interface pcisp_reg_if;
	logic [7:0] addr; // Register address from pointer
	logic [7:0] wdata; // Byte to store
	logic wr; // One-cycle write strobe
	logic rd; // One-cycle read-complete strobe
	logic [7:0] rdata; // Byte read back
	logic [3:0] slave_low; // Latched address bits
	// Serial engine drives requests
	modport engine (output addr, output wdata, output wr, output rd,
		input rdata, input slave_low);
	// Register store answers
	modport store (input addr, input wdata, input wr, input rd,
		output rdata, output slave_low);
endinterface : pcisp_reg_if
`default_nettype wire

/* File: pcisp_regs.sv */
// Register store with address latch, pushbutton clear and implemented-range guard
`timescale 1ns/1ps
`default_nettype none
module pcisp_regs
	import pcisp_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	input wire logic [3:0] addr_pins_sync, // Synchronised address pins
	// Engine side
	pcisp_reg_if.store bus,
	// Pushbutton clear pulse to event logic
	output logic clear_interrupt_pushbutton
);
	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [7:0] mem_q [0:PCISP_PTR_TOP]; // Flip-flop registers indexed by address
	logic [3:0] latch_q; // Captured address bits
	logic rst_seen_q; // Reset was active last cycle
	logic clr_q; // Registered pushbutton pulse
	wire in_range = (bus.addr <= PCISP_PTR_TOP); // Implemented addresses only
	wire do_wr = bus.wr && in_range; // Writes elsewhere are dropped

	// Capture the pins on the first cycle after release, never during reset
	always_ff @(posedge clk) begin
		rst_seen_q <= reset;
		if (!reset && rst_seen_q) begin
			latch_q <= addr_pins_sync;
		end
	end

	// Register writes; a pushbutton write is stored like any other and, with bit 7 set, also raises a one-cycle clear pulse
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i <= int'(PCISP_PTR_TOP); i++) mem_q[i] <= 8'h00;
			clr_q <= 1'b0;
		end else begin
			clr_q <= do_wr && (bus.addr == PCISP_PUSHBUTTON_REG) &&
				bus.wdata[PCISP_CLEAR_INTERRUPT_PUSHBUTTON_BIT];
			if (do_wr) begin
				mem_q[bus.addr[5:0]] <= bus.wdata;
			end
		end
	end

	// Out-of-range reads return zero
	assign bus.rdata = in_range ? mem_q[bus.addr[5:0]] : 8'h00;
	assign bus.slave_low = latch_q;
	assign clear_interrupt_pushbutton = clr_q;
endmodule : pcisp_regs
`default_nettype wire

/* File: pcisp_checker.sv */
// Concurrent checks on the pins of the serial slave port
`timescale 1ns/1ps
`default_nettype none
module pcisp_checker
	import pcisp_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Serial lines
	input wire logic scl,
	input wire logic serial_data_input,
	input wire logic serial_data_output_open_drain,
	input wire logic serial_data_output_oe,
	// Register side
	input wire logic clear_interrupt_pushbutton,
	input wire logic [7:0] pointer
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Data edges while the clock is high
	sequence start_s;
		scl && serial_data_input ##1 scl && !serial_data_input;
	endsequence
	sequence stop_s;
		scl && !serial_data_input ##1 scl && serial_data_input;
	endsequence
	od_low_a: assert property (!serial_data_output_open_drain)
		else $error("data output drives high");
	reset_quiet_a: assert property (disable iff (1'b0) reset |=>
		!serial_data_output_oe && pointer == PCISP_PTR_RESET && !clear_interrupt_pushbutton)
		else $error("outputs not quiet in reset");
	start_quiet_a: assert property (start_s |=> !serial_data_output_oe [*8])
		else $error("drive right after start");
	stop_release_a: assert property (stop_s |=> !serial_data_output_oe [*8])
		else $error("drive right after stop");
	// Sync delay is about three cycles, so five high samples leave margin
	oe_stable_a: assert property (scl [*5] |-> $stable(serial_data_output_oe))
		else $error("drive changed in clock high");
	oe_hold_a: assert property ($rose(serial_data_output_oe) |=> serial_data_output_oe [*6])
		else $error("drive too short");
	ptr_top_a: assert property ($past(pointer) == PCISP_PTR_TOP |-> pointer != 8'h27)
		else $error("pointer passed top");
	pulse_one_a: assert property (clear_interrupt_pushbutton |=> !clear_interrupt_pushbutton)
		else $error("clear pulse too long");
endmodule : pcisp_checker
bind pcisp_slave pcisp_checker chk_u (.clk, .reset, .scl, .serial_data_input,
	.serial_data_output_open_drain, .serial_data_output_oe,
	.clear_interrupt_pushbutton, .pointer);
`default_nettype wire

/* File: pcisp_master.sv */
// Bus master model that clocks the serial link
`timescale 1ns/1ps
`default_nettype none
module pcisp_master (
	// Serial lines
	output logic scl,
	output logic sda_m,
	input wire logic sda
);
	// Both lines rest high between frames
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	// One bit per 160 ns clock, data set while low
	task bit_io(input logic v, output logic s);
		#60 sda_m = v;
		#40 scl = 1'b1;
		#30 s = sda;
		#30 scl = 1'b0;
	endtask : bit_io
	// Data falls with clock high, also as repeated start
	task start_c();
		#40 sda_m = 1'b1;
		#40 scl = 1'b1;
		#80 sda_m = 1'b0;
		#80 scl = 1'b0;
	endtask : start_c
	// Data rises with clock high, releasing the bus
	task stop_c();
		#40 sda_m = 1'b0;
		#40 scl = 1'b1;
		#80 sda_m = 1'b1;
		#80;
	endtask : stop_c
	// Byte out, MSB first, ninth bit read back
	task wr_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], s);
		end
		bit_io(1'b1, s);
		ack = !s;
	endtask : wr_byte
	// Byte in, then the master's own acknowledge
	task rd_byte(input logic ack, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			b[i] = s;
		end
		bit_io(!ack, s);
	endtask : rd_byte
endmodule : pcisp_master
`default_nettype wire

/* File: test_poe_controller_i2c_slave_port.sv */
// Self-checking bench of the serial slave port
`timescale 1ns/1ps
`default_nettype none
module test_poe_controller_i2c_slave_port;
	import pcisp_pkg::*;
	logic clk, reset, int_act, od, oe, pulse, ack;
	logic [3:0] pins;
	logic [7:0] ptr, rb;
	wire logic scl, sda_m, sda;
	int n_fail = 0, check_count = 0, n_pulse = 0, cyc = 0;
	// Wired-AND data line with pull-up
	assign sda = sda_m & !(oe & !od);
	pcisp_slave dut_u (.clk, .reset, .scl, .serial_data_input(sda),
		.serial_data_output_open_drain(od), .serial_data_output_oe(oe),
		.address_select_bit3(pins[3]), .address_select_bit2(pins[2]),
		.address_select_bit1(pins[1]), .address_select_bit0(pins[0]),
		.interrupt_active(int_act), .clear_interrupt_pushbutton(pulse), .pointer(ptr));
	pcisp_master mst_u (.scl, .sda_m, .sda);
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Pulse count and hang limit
	always @(posedge clk) begin
		cyc++;
		if (pulse) n_pulse++;
		if (cyc == 20000) begin
			n_fail++;
			final_report();
		end
	end
	task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task wb(input logic [7:0] b, input logic e);
		mst_u.wr_byte(b, ack);
		chk("ack", {7'h0, ack}, {7'h0, e});
	endtask : wb
	// Burst write up to the top, then read back past it from a fresh pointer
	task t_write();
		logic [7:0] exp [4] = '{8'hA1, 8'hB2, 8'hC3, 8'hC3};
		mst_u.start_c();
		wb(8'h4A, 1'b1);
		wb(8'h24, 1'b1);
		wb(8'hA1, 1'b1);
		wb(8'hB2, 1'b1);
		wb(8'hC3, 1'b1);
		mst_u.stop_c();
		chk("ptr", ptr, 8'h26);
		mst_u.start_c();
		wb(8'h4A, 1'b1);
		wb(8'h24, 1'b1);
		mst_u.stop_c();
		chk("ptr", ptr, 8'h24);
		mst_u.start_c();
		wb(8'h4B, 1'b1);
		for (int i = 0; i < 4; i++) begin
			mst_u.rd_byte(i < 3, rb);
			chk("rdata", rb, exp[i]);
		end
		mst_u.stop_c();
	endtask : t_write
	// Foreign address refused; live pins no longer matter
	task t_foreign();
		@(posedge clk) pins <= 4'h6;
		mst_u.start_c();
		wb(8'h4C, 1'b0);
		mst_u.stop_c();
		mst_u.start_c();
		wb(8'h4A, 1'b1);
		wb(8'h00, 1'b1);
		mst_u.stop_c();
		chk("ptr", ptr, 8'h00);
	endtask : t_foreign
	// Global write read back through repeated starts
	task t_global();
		mst_u.start_c();
		wb(8'h60, 1'b1);
		wb(8'h10, 1'b1);
		wb(8'h5A, 1'b1);
		mst_u.start_c();
		wb(8'h4A, 1'b1);
		wb(8'h10, 1'b1);
		mst_u.start_c();
		wb(8'h4B, 1'b1);
		mst_u.rd_byte(1'b0, rb);
		chk("global", rb, 8'h5A);
		mst_u.stop_c();
	endtask : t_global
	// Alert response silent, then answering; then pushbutton clear
	task t_alert();
		mst_u.start_c();
		wb(8'h61, 1'b0);
		mst_u.stop_c();
		@(posedge clk) int_act <= 1'b1;
		mst_u.start_c();
		wb(8'h61, 1'b1);
		mst_u.rd_byte(1'b0, rb);
		chk("alert", rb, 8'h4B);
		mst_u.stop_c();
		chk("pulses", n_pulse[7:0], 8'h00);
		mst_u.start_c();
		wb(8'h4A, 1'b1);
		wb(PCISP_PUSHBUTTON_REG, 1'b1);
		wb(8'h80, 1'b1);
		mst_u.stop_c();
		chk("pulses", n_pulse[7:0], 8'h01);
		chk("ptr", ptr, 8'h1B);
	endtask : t_alert
	task final_report();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report
	initial begin
		reset = 1'b1;
		int_act = 1'b0;
		pins = 4'h5;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		repeat (8) @(posedge clk);
		#7;
		t_write();
		t_foreign();
		t_global();
		t_alert();
		final_report();
	end
endmodule : test_poe_controller_i2c_slave_port
`default_nettype wire
